// ==== hdl/phase_gen.sv ====
`timescale 1ns/1ns
`include "timer_two_consts.svh"
// ----------------------------------------------------------------
// machine cycle phase divider
// ----------------------------------------------------------------
module phase_gen (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // phase outputs
  output logic [3:0] phase_o,
  output logic state_tick_o
);
  // one clock is one oscillator period; twelve form a machine cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase_o <= 4'd0;
    end else if (phase_o == `OSC_PER_MACHINE - 4'd1) begin
      phase_o <= 4'd0;
    end else begin
      phase_o <= phase_o + 4'd1;
    end
  end
  // a state time is every other oscillator period
  assign state_tick_o = phase_o[0];
endmodule : phase_gen

// ==== hdl/timer_two.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "timer_two_consts.svh"
module timer_two
  import timer_two_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // pins
  input wire logic external_count_pin_i,
  input wire logic trigger_pin_i,
  // system outputs
  output logic timer_irq_o,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic overflow_pulse_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic down_count_enable_reg;
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] capture_low_reg;
  logic [7:0] capture_high_reg;
  logic [3:0] phase;
  logic state_tick;
  logic pin_sample_reg;
  logic pin_prev_reg;
  logic trig_sample_reg;
  logic trig_prev_reg;
  logic count_pending_reg;
  logic trig_event;
  logic serial_sel;
  logic count_step;
  logic [16:0] count_sum;
  logic overflow;
  logic wr_control;
  timer_mode_t mode;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // decode of the mode from control bits
  function automatic timer_mode_t decode_mode(input logic [7:0] c);
    if (!c[`BIT_RUN]) begin
      decode_mode = MODE_OFF;
    end else if (c[`BIT_RXCLK] || c[`BIT_TXCLK]) begin
      decode_mode = MODE_BAUD;
    end else if (c[`BIT_CPRL]) begin
      decode_mode = MODE_CAPTURE;
    end else begin
      decode_mode = MODE_RELOAD;
    end
  endfunction : decode_mode

  phase_gen i_phase_gen (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .phase_o(phase),
    .state_tick_o(state_tick)
  );

  assign mode = decode_mode(control_reg);
  assign serial_sel = control_reg[`BIT_RXCLK] | control_reg[`BIT_TXCLK];
  assign wr_control = wr_i && (addr_i == `OFS_CONTROL);

  // ----------------------------------------------------------------
  // pin sampling, once per machine cycle
  // ----------------------------------------------------------------
  // single sample per cycle; levels shorter than a cycle may be missed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_sample_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      trig_sample_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else if (phase == `PHASE_SAMPLE) begin
      pin_sample_reg <= external_count_pin_i;
      pin_prev_reg <= pin_sample_reg;
      trig_sample_reg <= trigger_pin_i;
      trig_prev_reg <= trig_sample_reg;
    end
  end

  // a high then low sample pair is a falling edge, held until it lands
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_pending_reg <= 1'b0;
    end else if (phase == `PHASE_LAND) begin
      count_pending_reg <= 1'b0;
    end else if (phase == `PHASE_SAMPLE + 4'd1 && pin_prev_reg && !pin_sample_reg) begin
      count_pending_reg <= 1'b1;
    end
  end

  // trigger edge seen one phase after the sample, gated by enable
  assign trig_event = (phase == `PHASE_SAMPLE + 4'd1) && trig_prev_reg && !trig_sample_reg
    && control_reg[`BIT_EXEN];

  // ----------------------------------------------------------------
  // count step and overflow
  // ----------------------------------------------------------------
  always_comb begin
    count_step = 1'b0;
    if (mode != MODE_OFF) begin
      if (control_reg[`BIT_SRC]) begin
        count_step = count_pending_reg && (phase == `PHASE_LAND);
      end else if (mode == MODE_BAUD) begin
        count_step = state_tick;
      end else begin
        count_step = (phase == `OSC_PER_MACHINE - 4'd1);
      end
    end
  end

  // one 17-bit sum: low carry reaches the high byte in the same cycle
  assign count_sum = {1'b0, count_high_reg, count_low_reg} + 17'd1;
  assign overflow = count_step && count_sum[16];

  // ----------------------------------------------------------------
  // count and capture/reload bytes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_low_reg <= `RST_BYTE;
      count_high_reg <= `RST_BYTE;
    end else if (wr_i && addr_i == `OFS_CNT_LOW) begin
      count_low_reg <= wdata_i;
    end else if (wr_i && addr_i == `OFS_CNT_HIGH) begin
      count_high_reg <= wdata_i;
    end else if (overflow && mode != MODE_CAPTURE) begin
      count_low_reg <= capture_low_reg;
      count_high_reg <= capture_high_reg;
    end else if (trig_event && !control_reg[`BIT_CPRL] && !serial_sel) begin
      count_low_reg <= capture_low_reg;
      count_high_reg <= capture_high_reg;
    end else if (count_step) begin
      count_low_reg <= count_sum[7:0];
      count_high_reg <= count_sum[15:8];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      capture_low_reg <= `RST_BYTE;
      capture_high_reg <= `RST_BYTE;
    end else if (wr_i && addr_i == `OFS_CAP_LOW) begin
      capture_low_reg <= wdata_i;
    end else if (wr_i && addr_i == `OFS_CAP_HIGH) begin
      capture_high_reg <= wdata_i;
    end else if (trig_event && control_reg[`BIT_CPRL] && !serial_sel) begin
      capture_low_reg <= count_low_reg;
      capture_high_reg <= count_high_reg;
    end
  end

  // ----------------------------------------------------------------
  // control register and flags
  // ----------------------------------------------------------------
  // a software write wins over a same-cycle hardware set
  always_comb begin
    control_next = control_reg;
    if (overflow && !serial_sel) begin
      control_next[`BIT_OVF] = 1'b1;
    end
    // in baud mode a trigger still flags, acting as an extra interrupt
    if (trig_event) begin
      control_next[`BIT_EXT] = 1'b1;
    end
    if (wr_control) begin
      control_next = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      control_reg <= `RST_CONTROL;
    end else begin
      control_reg <= control_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      down_count_enable_reg <= 1'b0;
    end else if (wr_i && addr_i == `OFS_MODE) begin
      down_count_enable_reg <= wdata_i[`BIT_DOWN_COUNT_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == `OFS_CONTROL) begin
      rdata_o <= control_reg;
    end else if (addr_i == `OFS_MODE) begin
      rdata_o <= {7'h00, down_count_enable_reg};
    end else if (addr_i == `OFS_CAP_LOW) begin
      rdata_o <= capture_low_reg;
    end else if (addr_i == `OFS_CAP_HIGH) begin
      rdata_o <= capture_high_reg;
    end else if (addr_i == `OFS_CNT_LOW) begin
      rdata_o <= count_low_reg;
    end else if (addr_i == `OFS_CNT_HIGH) begin
      rdata_o <= count_high_reg;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // interrupt from the flags; up/down mode masks the external flag
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      timer_irq_o <= 1'b0;
    end else begin
      timer_irq_o <= control_next[`BIT_OVF]
        | (control_next[`BIT_EXT] & !down_count_enable_reg);
    end
  end

  // serial clock routing, one pulse per overflow
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_baud_tick_o <= 1'b0;
      tx_baud_tick_o <= 1'b0;
      overflow_pulse_o <= 1'b0;
    end else begin
      rx_baud_tick_o <= overflow && control_reg[`BIT_RXCLK];
      tx_baud_tick_o <= overflow && control_reg[`BIT_TXCLK];
      overflow_pulse_o <= overflow;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wrap;
    overflow && !wr_control && !serial_sel;
  endsequence

  a_overflow_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_wrap |=> control_reg[`BIT_OVF])
    else $error("overflow flag not set after wrap");

  a_baud_no_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (serial_sel && !wr_control && !control_reg[`BIT_OVF]) |=> !control_reg[`BIT_OVF])
    else $error("overflow flag set in baud mode");

  a_ext_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trig_event && !wr_control) |=> control_reg[`BIT_EXT])
    else $error("external flag not set on trigger");

  a_stop_holds_count: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!control_reg[`BIT_RUN] && !wr_i && !trig_event) |=> $stable({count_high_reg, count_low_reg}))
    else $error("count moved while stopped");

  a_reload_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (overflow && mode == MODE_RELOAD && !wr_i)
      |=> {count_high_reg, count_low_reg} == $past({capture_high_reg, capture_low_reg}))
    else $error("reload value wrong after overflow");

  // a trigger reload works with the run bit clear as well
  a_trig_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trig_event && !control_reg[`BIT_CPRL] && !serial_sel && !wr_i)
      |=> {count_high_reg, count_low_reg} == $past({capture_high_reg, capture_low_reg}))
    else $error("trigger reload value wrong");

  a_capture_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trig_event && control_reg[`BIT_CPRL] && !serial_sel && !wr_i)
      |=> {capture_high_reg, capture_low_reg} == $past({count_high_reg, count_low_reg}))
    else $error("capture did not copy count");

  a_timer_rate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (count_step && mode == MODE_RELOAD && !control_reg[`BIT_SRC]) |=> !count_step [*8])
    else $error("timer stepped faster than a machine cycle");

  a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    control_reg[`BIT_OVF] |-> timer_irq_o)
    else $error("interrupt missing while overflow flag set");

  a_baud_tick: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (overflow && control_reg[`BIT_TXCLK]) |=> tx_baud_tick_o)
    else $error("transmit tick missing");
endmodule : timer_two

// ==== hdl/timer_two_consts.svh ====
`ifndef TIMER_TWO_CONSTS_SVH
`define TIMER_TWO_CONSTS_SVH
// register offsets (byte address in the special register space)
`define OFS_CONTROL 8'hc8
`define OFS_MODE 8'hc9
`define OFS_CAP_LOW 8'hca
`define OFS_CAP_HIGH 8'hcb
`define OFS_CNT_LOW 8'hcc
`define OFS_CNT_HIGH 8'hcd
// control bit positions
`define BIT_OVF 7
`define BIT_EXT 6
`define BIT_RXCLK 5
`define BIT_TXCLK 4
`define BIT_EXEN 3
`define BIT_RUN 2
`define BIT_SRC 1
`define BIT_CPRL 0
// mode register bit positions
`define BIT_DOWN_COUNT_ENABLE 0
// reset values
`define RST_CONTROL 8'h00
`define RST_BYTE 8'h00
// timing: oscillator periods per machine cycle and per state time
`define OSC_PER_MACHINE 4'd12
`define OSC_PER_STATE 4'd2
// phase in the machine cycle where the count pin is sampled (state 5 phase 2)
`define PHASE_SAMPLE 4'd9
// phase where a pending count lands (state 3 phase 1)
`define PHASE_LAND 4'd4
`endif

// ==== hdl/timer_two_pkg.sv ====
package timer_two_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_RELOAD, MODE_CAPTURE, MODE_BAUD} timer_mode_t;
endpackage : timer_two_pkg

// ==== testbench/pin_source.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far side: external count and trigger pins
// ----------------------------------------------------------------
module pin_source (
  // clock
  input wire logic sys_clk_i,
  // pins
  output logic external_count_pin_o,
  output logic trigger_pin_o
);
  // hold time per level; the device samples once per machine cycle
  localparam int HOLD = 14;
  // both pins idle high, as their pull-ups would leave them
  initial begin
    external_count_pin_o = 1'b1;
    trigger_pin_o = 1'b1;
  end
  // falling then rising level pairs on the count pin
  task automatic count_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      external_count_pin_o <= 1'b0;
      repeat (HOLD) @(posedge sys_clk_i);
      external_count_pin_o <= 1'b1;
      repeat (HOLD) @(posedge sys_clk_i);
    end
  endtask : count_pulses
  // one falling edge on the trigger pin, held long enough to be seen
  task automatic trigger_edge();
    @(posedge sys_clk_i);
    trigger_pin_o <= 1'b0;
    repeat (HOLD) @(posedge sys_clk_i);
    trigger_pin_o <= 1'b1;
    repeat (HOLD) @(posedge sys_clk_i);
  endtask : trigger_edge
endmodule : pin_source

// ==== testbench/timer2_capture_reload_counter_bench.sv ====
`timescale 1ns/1ns
module timer2_capture_reload_counter_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic count_pin, trig_pin;
  logic timer_irq_o, rx_baud_tick_o, tx_baud_tick_o, overflow_pulse_o;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  integer seed = 32'h071b4e3a;
  logic [7:0] rnd;
  int n;
  // 125 MHz clock
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  timer_two i_timer_two (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_count_pin_i(count_pin), .trigger_pin_i(trig_pin), .timer_irq_o(timer_irq_o),
    .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
    .overflow_pulse_o(overflow_pulse_o));
  pin_source i_pin_source (.sys_clk_i(sys_clk_i), .external_count_pin_o(count_pin),
    .trigger_pin_o(trig_pin));
  // ----------------------------------------------------------------
  // compare, bus tasks, verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // expected data is queued; the monitor pairs it with the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask : rd
  // count clocks up to the next overflow pulse, seen on falling edges
  task automatic wait_ovf(output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk_i);
      cnt++;
    end while (overflow_pulse_o !== 1'b1 && cnt < 2000);
  endtask : wait_ovf
  // reload value fffe, then the time between two overflows
  task automatic measure(input logic [7:0] ctrl, input int period);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hc8, ctrl);
    wait_ovf(n);
    wait_ovf(n);
    chk(n[7:0], period[7:0]);
    chk({6'h00, rx_baud_tick_o, tx_baud_tick_o}, {6'h00, ctrl[5:4]});
    rd(8'hc8, ctrl | ((ctrl[5:4] == 2'b00) ? 8'h80 : 8'h00));
    chk({7'h00, timer_irq_o}, {7'h00, ctrl[5:4] == 2'b00});
    wr(8'hc8, 8'h00);
    if (ctrl[5:4] == 2'b00) begin
      rd(8'hcc, 8'hfe);
      rd(8'hcd, 8'hff);
    end
    $display("test measure %h done", ctrl);
  endtask : measure
  task automatic wrap_up();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // read answer monitor: rdata_o stands only in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(rdata_o, exp_q.pop_front());
    end
    rd_seen <= rd_i;
  end
  // watchdog, well past the expected run length
  initial begin
    #(8 * 40000);
    err_total++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 8'hc8; a <= 8'hcd; a++) begin
      rd(a[7:0], 8'h00);
    end
    rd(8'hc0, 8'h00);
    $display("test reset done");
    // random control values, run bit kept clear so nothing moves
    for (int i = 0; i < 6; i++) begin
      rnd = 8'($random(seed));
      wr(8'hc8, rnd & 8'hfb);
      rd(8'hc8, rnd & 8'hfb);
    end
    wr(8'hc8, 8'h00);
    $display("test random control done");
    measure(8'h04, 24);
    measure(8'h34, 4);
    measure(8'h14, 4);
    measure(8'h24, 4);
    // trigger ignored while external enable is clear
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h10);
    wr(8'hc8, 8'h01);
    i_pin_source.trigger_edge();
    rd(8'hc8, 8'h01);
    rd(8'hca, 8'hfe);
    // capture on trigger sets external flag and interrupt
    wr(8'hc8, 8'h09);
    i_pin_source.trigger_edge();
    rd(8'hca, 8'h00);
    rd(8'hcb, 8'h10);
    rd(8'hc8, 8'h49);
    chk({7'h00, timer_irq_o}, 8'h01);
    wr(8'hc9, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    chk({7'h00, timer_irq_o}, 8'h00);
    wr(8'hc9, 8'h00);
    $display("test capture done");
    // reload on trigger, timer stopped
    wr(8'hca, 8'hcd);
    wr(8'hcb, 8'hab);
    wr(8'hc8, 8'h08);
    i_pin_source.trigger_edge();
    rd(8'hcc, 8'hcd);
    rd(8'hcd, 8'hab);
    rd(8'hc8, 8'h48);
    $display("test reload trigger done");
    // counter function counts falling edges of the count pin
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h06);
    i_pin_source.count_pulses(3);
    repeat (30) @(posedge sys_clk_i);
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'h03);
    repeat (50) @(posedge sys_clk_i);
    rd(8'hcc, 8'h03);
    rd(8'hcd, 8'h00);
    $display("test counter done");
    repeat (4) @(posedge sys_clk_i);
    wrap_up();
  end
endmodule : timer2_capture_reload_counter_bench
